/* File: shared/sw_monitor_pkg.sv */
// Constants for the switch and analogue monitor block.
// Assumes a 250 MHz reference clock and an APB register bus with 32-bit data.
package sw_monitor_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_HALT_REF = 8'h04;
    localparam logic [7:0] OFS_DEMAND_REF = 8'h08;
    localparam logic [7:0] OFS_HALT_LIMIT = 8'h0C;
    localparam logic [7:0] OFS_DEMAND_LIMIT = 8'h10;
    localparam logic [7:0] OFS_FILTER = 8'h14;
    localparam logic [7:0] OFS_SUBST = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_HALT_VAL = 8'h20;
    localparam logic [7:0] OFS_DEMAND_VAL = 8'h24;
    // Control field positions
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_AHALT_BIT = 1;
    localparam int CTRL_FALLBACK_BIT = 2;
    localparam int CTRL_HALT_ASG_LSB = 3;
    localparam int CTRL_CLR_ASG_LSB = 6;
    localparam int CTRL_CAL_ASG_LSB = 9;
    localparam int CTRL_INV_LSB = 12;
    localparam int CTRL_WIDTH = 14;
    // Input numbers used in assignment fields
    localparam logic [2:0] ASG_NONE = 3'h0;
    localparam logic [2:0] ASG_IN_A = 3'h4;
    localparam logic [2:0] ASG_IN_B = 3'h5;
    // Reset values
    localparam logic [13:0] CTRL_RESET = 14'h0000;
    localparam logic [31:0] REF_RESET = 32'hFFFF_0000;
    localparam logic [31:0] LIMIT_RESET = 32'hFFFF_0000;
    localparam logic [7:0] FILTER_RESET = 8'h01;
    localparam logic [15:0] SUBST_RESET = 16'h0000;
    // Percent is held in hundredths of a percent
    localparam logic [15:0] PCT_FULL = 16'h2710;
    localparam int PCT_FRAC = 8;
    // Timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam longint DEBOUNCE_MS = 20;
    localparam longint FILTER_RATE_MHZ = 62500;
    // Picoseconds per second times one thousand, sized so no tool truncates it
    localparam longint PS_PER_S_MILLI = 64'h00038D7EA4C68000;
    localparam int DEBOUNCE_CYCLES = int'((DEBOUNCE_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int FILTER_CYCLES = int'(PS_PER_S_MILLI / (FILTER_RATE_MHZ * CLK_PERIOD_PS));
endpackage

/* File: design/sw_monitor.sv */
// Switch function mapping, debounce, analogue scaling, filter and limit check.
// Assumes digital pins are asynchronous and converter samples come on ref_clk_i.
//
// What this block does
// - Second input digital unless both PWM and halt
// - Switch status 1 active regardless of wiring
// - Halt state follows assigned input five only
// - Calibration starts on rising edge only
// - Assignment selects input; zero holds off
// - Only inputs four and five exist
// - Halt accepts input five when allowed
// - Clear/calibrate take four; five without halt
// - No fault detection on digital inputs
// - Demand pin used only for analogue source
// - Halt level read from analogue pin
// - Linear scaling, inverted references allowed
// - Raw and filtered values both visible
// - Filter setting 1..255, one disables
// - Time constant equals setting over 62.5
// - Fault when outside low or high limit
// - Limits compare raw magnitudes only
// - Fault sets its own sensor flag
// - Unassigned analogue input never checked
// - Halt fault uses last or substitute
// - Halt fault and alarm rise together
`timescale 1ns/10ps
module sw_monitor
    import sw_monitor_pkg::*;
#(
    parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
    parameter int FILTER_LEN = FILTER_CYCLES
)
(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic digital_input_a_i,
    input wire logic digital_input_b_i,
    input wire logic [15:0] halt_analog_pin_i,
    input wire logic [15:0] demand_analog_pin_i,
    output logic input_b_digital_o,
    output logic halt_switch_state_o,
    output logic fault_clear_pulse_o,
    output logic calibrate_pulse_o,
    output logic [15:0] halt_sensor_pct_o,
    output logic [15:0] demand_pct_o,
    output logic halt_fault_o,
    output logic demand_fault_o,
    output logic summary_alarm_o
);

////////////////////////////////////////////////////////////////////////////////
// Configuration registers

logic [13:0] ctrl_q;
logic [15:0] ref_lo_q [2];
logic [15:0] ref_hi_q [2];
logic [15:0] lim_lo_q [2];
logic [15:0] lim_hi_q [2];
logic [7:0] filt_q [2];
logic [15:0] subst_q;

wire setpoint_source_select = ctrl_q[CTRL_SRC_BIT];
wire analog_halt_enable = ctrl_q[CTRL_AHALT_BIT];
wire halt_fallback_select = ctrl_q[CTRL_FALLBACK_BIT];
wire [2:0] halt_input_assignment = ctrl_q[CTRL_HALT_ASG_LSB +: 3];
wire [2:0] fault_clear_input_assignment = ctrl_q[CTRL_CLR_ASG_LSB +: 3];
wire [2:0] calibrate_input_assignment = ctrl_q[CTRL_CAL_ASG_LSB +: 3];
wire [1:0] pin_invert = ctrl_q[CTRL_INV_LSB +: 2];

// Bus phase decode
wire setup_ph = psel_i && !penable_i;
wire access_ph = psel_i && penable_i;
wire wr_en = access_ph && pwrite_i && clk_en_i;
wire is_rw = paddr_i <= OFS_SUBST && paddr_i[1:0] == 2'b00;
wire is_ro = paddr_i == OFS_STATUS || paddr_i == OFS_HALT_VAL || paddr_i == OFS_DEMAND_VAL;
wire bad_addr = !(is_rw || (is_ro && !pwrite_i));

// Zero wait states; read data is captured in the setup cycle
assign pready_o = access_ph;
assign pslverr_o = access_ph && bad_addr;

////////////////////////////////////////////////////////////////////////////////
// Digital inputs: synchroniser, polarity, debounce

logic [1:0] pin_raw;
logic [1:0] sync1_q;
logic [1:0] sync2_q;
logic [1:0] deb_q;
logic [22:0] deb_cnt_q [2];

assign pin_raw = {digital_input_b_i, digital_input_a_i};

// Two-stage synchroniser, the first stage feeds nothing else
always_ff @(posedge ref_clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        sync1_q <= 2'h0;
        sync2_q <= 2'h0;
    end
    else if (clk_en_i)
    begin
        sync1_q <= pin_raw;
        sync2_q <= sync1_q;
    end
end

genvar gi;
generate
    for (gi = 0; gi < 2; gi++)
    begin : g_deb
        // Level after wiring polarity, so 1 always means switch active
        wire lvl = sync2_q[gi] ^ pin_invert[gi];
        wire differs = lvl != deb_q[gi];
        wire done = deb_cnt_q[gi] == 23'(DEBOUNCE_LEN - 1);
        // A level must stand for the full span; shorter pulses vanish
        always_ff @(posedge ref_clk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                deb_cnt_q[gi] <= 23'h000000;
                deb_q[gi] <= 1'b0;
            end
            else if (clk_en_i)
            begin
                if (!differs)
                    deb_cnt_q[gi] <= 23'h000000;
                else if (done)
                begin
                    deb_cnt_q[gi] <= 23'h000000;
                    deb_q[gi] <= lvl;
                end
                else
                    deb_cnt_q[gi] <= deb_cnt_q[gi] + 23'h000001;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Switch function mapping

// Pin B is a digital input unless the PWM setpoint and analogue halt are both selected
wire b_is_digital = !(setpoint_source_select && analog_halt_enable);
// Only inputs 4 and 5 exist; any other code reads as inactive
wire halt_on_b = halt_input_assignment == ASG_IN_B;
wire b_free = b_is_digital && !halt_on_b;

wire halt_d = halt_on_b && b_is_digital && deb_q[1];
wire clear_lvl = (fault_clear_input_assignment == ASG_IN_A && deb_q[0]) ||
                 (fault_clear_input_assignment == ASG_IN_B && b_free && deb_q[1]);
wire cal_lvl = (calibrate_input_assignment == ASG_IN_A && deb_q[0]) ||
               (calibrate_input_assignment == ASG_IN_B && b_free && deb_q[1]);

logic clear_prev_q;
logic cal_prev_q;
logic halt_sw_q;
logic clear_pulse_q;
logic cal_pulse_q;

// Edge detection; a steady level never repeats the action
always_ff @(posedge ref_clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        clear_prev_q <= 1'b0;
        cal_prev_q <= 1'b0;
        halt_sw_q <= 1'b0;
        clear_pulse_q <= 1'b0;
        cal_pulse_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
        clear_prev_q <= clear_lvl;
        cal_prev_q <= cal_lvl;
        halt_sw_q <= halt_d;
        clear_pulse_q <= clear_lvl && !clear_prev_q;
        cal_pulse_q <= cal_lvl && !cal_prev_q;
    end
end

// Digital inputs carry no fault monitor of any kind
assign halt_switch_state_o = halt_sw_q;
assign fault_clear_pulse_o = clear_pulse_q;
assign calibrate_pulse_o = cal_pulse_q;
assign input_b_digital_o = b_is_digital;

////////////////////////////////////////////////////////////////////////////////
// Filter rate tick

logic [22:0] tick_cnt_q;
wire tick = tick_cnt_q == 23'(FILTER_LEN - 1);

// Fixed update rate so the setting maps straight onto time constant
always_ff @(posedge ref_clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
        tick_cnt_q <= 23'h000000;
    else if (clk_en_i)
        tick_cnt_q <= tick ? 23'h000000 : tick_cnt_q + 23'h000001;
end

////////////////////////////////////////////////////////////////////////////////
// Analogue channels: 0 is halt, 1 is demand

logic [15:0] raw_q [2];
logic [15:0] pct_q [2];
logic [23:0] acc_q [2];
logic [1:0] fault_q;
wire [15:0] pin_an [2];
wire [1:0] ch_used;

assign pin_an[0] = halt_analog_pin_i;
assign pin_an[1] = demand_analog_pin_i;
assign ch_used = {!setpoint_source_select, analog_halt_enable};

generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ch
        // Signed distances; a negative span means inverted references
        wire signed [17:0] num = $signed({2'b00, raw_q[gi]}) - $signed({2'b00, ref_lo_q[gi]});
        wire signed [17:0] den = $signed({2'b00, ref_hi_q[gi]}) - $signed({2'b00, ref_lo_q[gi]});
        wire signed [17:0] n_adj = den[17] ? -num : num;
        wire [16:0] d_abs = den[17] ? 17'(-den) : 17'(den);
        wire [16:0] n_abs = 17'(n_adj);
        wire [31:0] prod = 32'(n_abs) * 32'(PCT_FULL);
        wire [31:0] quo = d_abs == 17'h00000 ? 32'h00000000 : prod / 32'(d_abs);
        // Out-of-span readings are clamped to the 0..100 % range
        wire [15:0] scaled = n_adj[17] ? 16'h0000 :
                             quo > 32'(PCT_FULL) ? PCT_FULL : quo[15:0];
        // First-order step: move 1/setting of the gap per tick
        wire [7:0] div = filt_q[gi] == 8'h00 ? 8'h01 : filt_q[gi];
        wire signed [24:0] gap = $signed({1'b0, scaled, 8'h00}) - $signed({1'b0, acc_q[gi]});
        wire signed [24:0] step = gap / $signed({17'h00000, div});
        wire [23:0] acc_d = 24'($signed({1'b0, acc_q[gi]}) + step);
        // Raw magnitudes only, no matter which reference is 0 %
        wire out_lim = raw_q[gi] < lim_lo_q[gi] || raw_q[gi] > lim_hi_q[gi];

        always_ff @(posedge ref_clk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                raw_q[gi] <= 16'h0000;
                acc_q[gi] <= 24'h000000;
                fault_q[gi] <= 1'b0;
            end
            else if (clk_en_i)
            begin
                raw_q[gi] <= pin_an[gi];
                if (tick)
                    acc_q[gi] <= acc_d;
                fault_q[gi] <= ch_used[gi] && out_lim;
            end
        end
        assign pct_q[gi] = acc_q[gi][PCT_FRAC +: 16];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Fault handling and outputs

logic [15:0] last_valid_q;
logic [15:0] halt_out_q;
logic [15:0] demand_out_q;

// Fallback value during a halt fault, last good value or substitute
always_ff @(posedge ref_clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        last_valid_q <= 16'h0000;
        halt_out_q <= 16'h0000;
        demand_out_q <= 16'h0000;
    end
    else if (clk_en_i)
    begin
        if (!fault_q[0])
            last_valid_q <= pct_q[0];
        if (!analog_halt_enable)
            halt_out_q <= 16'h0000;
        else if (fault_q[0])
            halt_out_q <= halt_fallback_select ? subst_q : last_valid_q;
        else
            halt_out_q <= pct_q[0];
        demand_out_q <= ch_used[1] ? pct_q[1] : 16'h0000;
    end
end

assign halt_sensor_pct_o = halt_out_q;
assign demand_pct_o = demand_out_q;
assign halt_fault_o = fault_q[0];
assign demand_fault_o = fault_q[1];
// Same flop source as the halt flag, so both rise in one cycle
assign summary_alarm_o = |fault_q;

////////////////////////////////////////////////////////////////////////////////
// Register write and read

wire [31:0] status_w = {22'h000000, fault_q, input_b_digital_o, cal_lvl, clear_lvl,
                        halt_sw_q, deb_q, sync2_q};
logic [31:0] rd_mux;

always_comb
begin
    unique case (paddr_i)
        OFS_CTRL: rd_mux = {18'h00000, ctrl_q};
        OFS_HALT_REF: rd_mux = {ref_hi_q[0], ref_lo_q[0]};
        OFS_DEMAND_REF: rd_mux = {ref_hi_q[1], ref_lo_q[1]};
        OFS_HALT_LIMIT: rd_mux = {lim_hi_q[0], lim_lo_q[0]};
        OFS_DEMAND_LIMIT: rd_mux = {lim_hi_q[1], lim_lo_q[1]};
        OFS_FILTER: rd_mux = {16'h0000, filt_q[1], filt_q[0]};
        OFS_SUBST: rd_mux = {16'h0000, subst_q};
        OFS_STATUS: rd_mux = status_w;
        OFS_HALT_VAL: rd_mux = {pct_q[0], raw_q[0]};
        OFS_DEMAND_VAL: rd_mux = {pct_q[1], raw_q[1]};
        default: rd_mux = 32'h00000000;
    endcase
end

// Writes land on the access edge; unmapped writes are dropped
always_ff @(posedge ref_clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        ctrl_q <= CTRL_RESET;
        ref_lo_q <= '{REF_RESET[15:0], REF_RESET[15:0]};
        ref_hi_q <= '{REF_RESET[31:16], REF_RESET[31:16]};
        lim_lo_q <= '{LIMIT_RESET[15:0], LIMIT_RESET[15:0]};
        lim_hi_q <= '{LIMIT_RESET[31:16], LIMIT_RESET[31:16]};
        filt_q <= '{FILTER_RESET, FILTER_RESET};
        subst_q <= SUBST_RESET;
        prdata_o <= 32'h00000000;
    end
    else if (clk_en_i)
    begin
        if (setup_ph && !pwrite_i)
            prdata_o <= rd_mux;
        if (wr_en)
        begin
            unique case (paddr_i)
                OFS_CTRL: ctrl_q <= pwdata_i[CTRL_WIDTH-1:0];
                OFS_HALT_REF: {ref_hi_q[0], ref_lo_q[0]} <= pwdata_i;
                OFS_DEMAND_REF: {ref_hi_q[1], ref_lo_q[1]} <= pwdata_i;
                OFS_HALT_LIMIT: {lim_hi_q[0], lim_lo_q[0]} <= pwdata_i;
                OFS_DEMAND_LIMIT: {lim_hi_q[1], lim_lo_q[1]} <= pwdata_i;
                OFS_FILTER: {filt_q[1], filt_q[0]} <= pwdata_i[15:0];
                OFS_SUBST: subst_q <= pwdata_i[15:0];
                default: ;
            endcase
        end
    end
end

endmodule

/* File: tb/field_model.sv */
// Model of the switches and analogue sensors wired to the monitor.
// Assumes the bench calls its tasks; every change lands just after a rising edge.
`timescale 1ns/10ps
module field_model
(
    input wire logic ref_clk_i,
    output logic din_a_o,
    output logic din_b_o,
    output logic [15:0] halt_smp_o,
    output logic [15:0] demand_smp_o
);
    // Idle switches open, converters at zero
    initial
    begin
        din_a_o = 1'b0;
        din_b_o = 1'b0;
        halt_smp_o = 16'h0000;
        demand_smp_o = 16'h0000;
    end
    // Switch levels hold until the next call, so pulse length is up to the caller
    task automatic pins(input logic a, input logic b);
        @(posedge ref_clk_i);
        din_a_o <= a;
        din_b_o <= b;
    endtask
    // New converter samples, same clock as the monitor
    task automatic sample(input logic [15:0] h, input logic [15:0] d);
        @(posedge ref_clk_i);
        halt_smp_o <= h;
        demand_smp_o <= d;
    endtask
endmodule

/* File: tb/sw_monitor_properties.sv */
// Port checker for the switch and analogue monitor.
// Assumes it is bound to sw_monitor and sees only that module's ports.
`timescale 1ns/10ps
module sw_monitor_properties
    import sw_monitor_pkg::*;
#(
    parameter int DEBOUNCE_LEN = 8,
    parameter int FILTER_LEN = 4
)
(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic digital_input_a_i,
    input wire logic digital_input_b_i,
    input wire logic halt_switch_state_o,
    input wire logic fault_clear_pulse_o,
    input wire logic calibrate_pulse_o,
    input wire logic [15:0] halt_sensor_pct_o,
    input wire logic [15:0] demand_pct_o,
    input wire logic halt_fault_o,
    input wire logic demand_fault_o,
    input wire logic summary_alarm_o
);
    logic [31:0] stab_a_q;
    logic [31:0] stab_b_q;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////////
    // Cycles each pin held its level; saturating keeps long runs harmless
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            stab_a_q <= 32'h00000000;
            stab_b_q <= 32'h00000000;
        end
        else
        begin
            // Wide enough for the full-length debounce span
            stab_a_q <= $changed(digital_input_a_i) ? 32'h00000000 : stab_a_q + 32'(stab_a_q != 32'hFFFFFFFF);
            stab_b_q <= $changed(digital_input_b_i) ? 32'h00000000 : stab_b_q + 32'(stab_b_q != 32'hFFFFFFFF);
        end
    end
    ////////////////////////////////////////////////////////////////
    // Pulses last one cycle; bus answers in the access cycle itself
    sequence s_pulse(x);
        x ##1 !x;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence
    property p_clr_pulse;
        fault_clear_pulse_o |-> s_pulse(fault_clear_pulse_o);
    endproperty
    property p_cal_pulse;
        calibrate_pulse_o |-> s_pulse(calibrate_pulse_o);
    endproperty
    property p_ready;
        s_access |-> pready_o;
    endproperty
    property p_err_access;
        pslverr_o |-> s_access;
    endproperty
    property p_alarm;
        summary_alarm_o == (halt_fault_o || demand_fault_o);
    endproperty
    property p_halt_pct;
        halt_sensor_pct_o <= PCT_FULL;
    endproperty
    property p_demand_pct;
        demand_pct_o <= PCT_FULL;
    endproperty
    property p_halt_deb;
        $changed(halt_switch_state_o) |-> stab_b_q >= DEBOUNCE_LEN;
    endproperty
    property p_clr_deb;
        $rose(fault_clear_pulse_o) |-> (stab_a_q >= DEBOUNCE_LEN) || (stab_b_q >= DEBOUNCE_LEN);
    endproperty
    a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse too long");
    a_cal_pulse: assert property (p_cal_pulse) else $error("calibrate pulse too long");
    a_ready: assert property (p_ready) else $error("no ready in access");
    a_err_access: assert property (p_err_access) else $error("error outside access");
    a_alarm: assert property (p_alarm) else $error("alarm not tied to faults");
    a_halt_pct: assert property (p_halt_pct) else $error("halt percent above full");
    a_demand_pct: assert property (p_demand_pct) else $error("demand percent above full");
    a_halt_deb: assert property (p_halt_deb) else $error("halt changed before debounce");
    a_clr_deb: assert property (p_clr_deb) else $error("clear before debounce");
endmodule
bind sw_monitor sw_monitor_properties #(.DEBOUNCE_LEN(DEBOUNCE_LEN), .FILTER_LEN(FILTER_LEN)) chk (.ref_clk_i,
    .arst_n_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .digital_input_a_i, .digital_input_b_i,
    .halt_switch_state_o, .fault_clear_pulse_o, .calibrate_pulse_o, .halt_sensor_pct_o, .demand_pct_o,
    .halt_fault_o, .demand_fault_o, .summary_alarm_o);

/* File: tb/tb_top.sv */
// Self-checking bench for the switch and analogue monitor.
// Assumes short debounce and filter counts set by parameter.
`timescale 1ns/10ps
module tb_top;
    import sw_monitor_pkg::*;
    localparam int DEB = 8;
    logic ref_clk = 1'b0;
    logic arst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic din_a, din_b, b_dig, halt_st, clr_p, cal_p, halt_flt, dem_flt, alarm;
    logic [15:0] halt_smp, dem_smp, halt_pct, dem_pct;
    int err_count = 0;
    int check_count = 0;
    int clr_n = 0;
    int cal_n = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////
    sw_monitor #(.DEBOUNCE_LEN(DEB), .FILTER_LEN(4)) dut (.ref_clk_i(ref_clk), .arst_n_i(arst_n),
        .clk_en_i(1'b1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .digital_input_a_i(din_a), .digital_input_b_i(din_b), .halt_analog_pin_i(halt_smp),
        .demand_analog_pin_i(dem_smp), .input_b_digital_o(b_dig), .halt_switch_state_o(halt_st),
        .fault_clear_pulse_o(clr_p), .calibrate_pulse_o(cal_p), .halt_sensor_pct_o(halt_pct),
        .demand_pct_o(dem_pct), .halt_fault_o(halt_flt), .demand_fault_o(dem_flt), .summary_alarm_o(alarm));
    field_model fm (.ref_clk_i(ref_clk), .din_a_o(din_a), .din_b_o(din_b), .halt_smp_o(halt_smp),
        .demand_smp_o(dem_smp));
    // Clock, pulse tally and hang guard
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        clr_n += int'(clr_p === 1'b1);
        cal_n += int'(cal_p === 1'b1);
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One APB transfer; request held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for ready
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ctl(input logic [2:0] src_ah_fb, input logic [2:0] h, input logic [2:0] c, input logic [2:0] k);
        logic e;
        apb(1'b1, OFS_CTRL, {20'h00000, k, c, h, src_ah_fb}, e);
    endtask
    // Low-side wiring on pin A: an open pin reads active, a closed one inactive
    task automatic t_invert();
        logic e;
        clr_n = 0;
        apb(1'b1, OFS_CTRL, 32'h00001100, e);
        wt(3 * DEB);
        fm.pins(1'b1, 1'b0);
        wt(3 * DEB);
        chk(32'(clr_n), 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0, e);
        chk(32'(r[5]), 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    // Reset values, read-only and unmapped places
    task automatic t_regs();
        logic e;
        apb(1'b0, OFS_CTRL, 32'h0, e);
        chk(r, 32'h00000000);
        apb(1'b0, OFS_HALT_REF, 32'h0, e);
        chk(r, REF_RESET);
        apb(1'b1, OFS_FILTER, 32'h00000808, e);
        apb(1'b0, OFS_FILTER, 32'h0, e);
        chk(r, 32'h00000808);
        apb(1'b1, OFS_FILTER, 32'h00000101, e);
        apb(1'b1, OFS_STATUS, 32'hFFFFFFFF, e);
        chk(32'(e), 32'h1);
        apb(1'b0, 8'h28, 32'h0, e);
        chk(32'(e), 32'h1);
    endtask
    // Halt switch on pin B: short pulse dropped, long one taken, blocked when B is not digital
    task automatic t_halt();
        ctl(3'b000, ASG_IN_B, ASG_NONE, ASG_NONE);
        fm.pins(1'b0, 1'b1);
        wt(3);
        fm.pins(1'b0, 1'b0);
        wt(20);
        chk(32'(halt_st), 32'h0);
        fm.pins(1'b0, 1'b1);
        wt(DEB + 8);
        chk(32'(halt_st), 32'h1);
        chk(32'(b_dig), 32'h1);
        ctl(3'b011, ASG_IN_B, ASG_NONE, ASG_NONE);
        wt(DEB + 8);
        chk(32'(b_dig), 32'h0);
        chk(32'(halt_st), 32'h0);
        fm.pins(1'b0, 1'b0);
        wt(DEB + 8);
    endtask
    // Hold one pin long and count clear and calibrate pulses
    task automatic edge1(input logic [2:0] h, input logic [2:0] c, input logic [2:0] k, input logic b,
        input int ec, input int ek);
        ctl(3'b000, h, c, k);
        clr_n = 0;
        cal_n = 0;
        fm.pins(!b, b);
        wt(3 * DEB);
        fm.pins(1'b0, 1'b0);
        wt(2 * DEB);
        chk(32'(clr_n), 32'(ec));
        chk(32'(cal_n), 32'(ek));
        chk(32'(alarm), 32'h0);
    endtask
    // Scaling, inverted refs, limits, fallback and unassigned input
    task automatic t_analog();
        logic e;
        apb(1'b1, OFS_HALT_REF, 32'h0BB803E8, e);
        apb(1'b1, OFS_DEMAND_REF, 32'h03E80BB8, e);
        apb(1'b1, OFS_HALT_LIMIT, 32'h0DAC01F4, e);
        apb(1'b1, OFS_DEMAND_LIMIT, 32'h0DAC01F4, e);
        apb(1'b1, OFS_SUBST, 32'h000004D2, e);
        ctl(3'b110, ASG_NONE, ASG_NONE, ASG_NONE);
        fm.sample(16'h07D0, 16'h05DC);
        wt(12);
        chk(halt_pct, 16'h1388);
        chk(dem_pct, 16'h1D4C);
        apb(1'b0, OFS_HALT_VAL, 32'h0, e);
        chk(r, 32'h138807D0);
        fm.sample(16'h0064, 16'h05DC);
        wt(5);
        chk({halt_flt, dem_flt, alarm}, 3'b101);
        chk(halt_pct, 16'h04D2);
        ctl(3'b010, ASG_NONE, ASG_NONE, ASG_NONE);
        wt(5);
        chk(halt_pct, 16'h1388);
        fm.sample(16'h07D0, 16'h0FA0);
        wt(12);
        chk({halt_flt, dem_flt}, 2'b01);
        ctl(3'b011, ASG_NONE, ASG_NONE, ASG_NONE);
        wt(12);
        chk({dem_flt, dem_pct}, 17'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wt(6);
        arst_n <= 1'b1;
        t_regs();
        t_halt();
        edge1(ASG_NONE, ASG_IN_A, ASG_NONE, 1'b0, 1, 0);
        edge1(ASG_NONE, ASG_NONE, ASG_IN_A, 1'b0, 0, 1);
        edge1(ASG_NONE, ASG_NONE, ASG_IN_B, 1'b1, 0, 1);
        edge1(ASG_IN_B, ASG_IN_B, ASG_IN_B, 1'b1, 0, 0);
        t_invert();
        t_analog();
        test_done();
    end
endmodule
